// >>> hw/ssc_serial_regs.sv
// Purpose: serial control and readback registers of a dual-band synthesizer
// Assumes: host clocks sclk only inside enable-low frames, idle high
// Notes: frame length selects the register written; mclk is the reference
//
// Function
// R1: done flag set when conversion finishes
// R2: done flag cleared with sample command
// R3: first input pin level in A6
// R4: pin levels caught at enable fall
// R5: six-bit result in A5..A0, MSB first
// R6: ADC readback works with 8/9/16 clocks
// R7: count-complete set after full window
// R8: count-complete cleared with frequency sample
// R9: second input pin level in F22
// R10: count readback takes 24 clocks
// R11: sample command low holds converter initialised
// R12: ADC read select presents ADC readback
// R13: host writes reserved control bit zero
// R14: channel bit selects analog input
// R15: open-drain output low or floating
// R16: push-pull outputs follow their bits
// R17: count read select presents count readback
// R18: divider write aborts count during conversion
// R19: reference divider sent as three bytes
// R20: loop divider sent as two bytes
// R21: loop bit 15 selects detector zone
// R22: host sets a read select first
// R23: no count start during conversion; code starts the count on fsmpl with standby off, whatever ismpl
// R24: counter held all ones when idle
// R25: one-byte read: flag top, value low
// R26: MSB first, one bit per clock
`timescale 1ns/1ps
module ssc_serial_regs #(
    parameter int NARROW_CYCLES = ssc_pkg::WIN_NARROW_CYCLES,
    parameter int WIDE_CYCLES = ssc_pkg::WIN_WIDE_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic serialEnableN,
    input wire logic sdataIn,
    output logic sdataOut,
    input wire logic inC,
    input wire logic inD,
    input wire logic freqIn,
    input wire logic adcDone,
    input wire logic [5:0] adcValue,
    output logic outAOut,
    output logic outAOe,
    output logic outB,
    output logic outC,
    output logic outD,
    output ssc_pkg::ssc_cfg_s cfg
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    ssc_pkg::ssc_link_s lnk_r;
    ssc_pkg::ssc_link_s lnk_nxt;
    ssc_pkg::ssc_st_s st_r;
    ssc_pkg::ssc_st_s st_nxt;
    logic sdataOut_r;
    logic linkRstN;
    logic enS;
    logic inCs;
    logic inDs;
    logic freqS;
    logic enFall;
    logic capture;
    logic readA;
    logic readF;
    logic ismpl;
    logic fsmpl;
    logic stby;
    logic rWrite;
    logic winLast;
    logic freqEdge;

    // bit of the readback word launched after n rising clocks
    function automatic logic readBit(input logic [23:0] w, input logic [4:0] n);
        logic b;
        b = 1'b0;
        if (n <= ssc_pkg::READ_TOP) begin
            b = w[ssc_pkg::READ_TOP - n];
        end
        return b;
    endfunction : readBit

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    ssc_sync #(
        .W(4),
        .RESET_VAL(4'h8)
    ) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d({serialEnableN, inC, inD, freqIn}),
        .q({enS, inCs, inDs, freqS})
    );

    ////////////////////////////////////////////////////////////////////////////
    // link domain: shift in on rising, launch out on falling
    // cleared only once mclk has taken the finished frame
    assign linkRstN = nrst & ~(serialEnableN & st_r.captured);

    always_comb begin
        lnk_nxt = lnk_r;
        // R26: MSB first shift
        lnk_nxt.shift = {lnk_r.shift[22:0], sdataIn};
        if (lnk_r.bitCount != ssc_pkg::LEN_MAX) begin
            lnk_nxt.bitCount = lnk_r.bitCount + 5'h01;
        end
    end

    always_ff @(posedge sclk or negedge linkRstN) begin
        if (!linkRstN) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    // R10: 24 bits then zeros
    always_ff @(negedge sclk or negedge linkRstN) begin
        if (!linkRstN) begin
            sdataOut_r <= 1'b0;
        end else begin
            sdataOut_r <= readBit(st_r.snapshot, lnk_r.bitCount);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mclk domain decode
    assign enFall = st_r.enPrev & ~enS;
    assign capture = enS & ~st_r.captured;
    assign readA = st_r.cReg[ssc_pkg::C_READA_BIT];
    assign readF = st_r.cReg[ssc_pkg::C_READF_BIT];
    assign ismpl = st_r.cReg[ssc_pkg::C_ISMPL_BIT];
    assign fsmpl = st_r.rReg[ssc_pkg::R_FSMPL_BIT];
    assign stby = st_r.rReg[ssc_pkg::R_STBY_BIT];
    assign rWrite = capture & ~readA & ~readF & (lnk_r.bitCount == ssc_pkg::LEN_R);
    assign freqEdge = freqS & ~st_r.freqPrev;
    assign winLast = st_r.winCount == (st_r.rReg[ssc_pkg::R_ACQ_BIT]
        ? ssc_pkg::WIN_W'(WIDE_CYCLES - 1) : ssc_pkg::WIN_W'(NARROW_CYCLES - 1));

    always_comb begin
        st_nxt = st_r;
        st_nxt.enPrev = enS;
        st_nxt.freqPrev = freqS;
        if (!enS) begin
            st_nxt.captured = 1'b0;
        end
        // R4: pins caught as the read frame opens
        if (enFall) begin
            if (readA) begin
                // R3: pin C beside flag
                // R6: A byte, then pin D, then zeros
                // R25: flag on top, value in low six
                st_nxt.snapshot = {st_r.eoc, inCs, st_r.adcResult, inDs, 15'h0000};
            end else if (readF) begin
                // R9: pin D beside the flag
                st_nxt.snapshot = {st_r.cc, inDs, st_r.fcount};
            end
        end
        // frame end: length picks the register
        if (capture) begin
            st_nxt.captured = 1'b1;
            if (lnk_r.bitCount == ssc_pkg::LEN_C) begin
                st_nxt.cReg = lnk_r.shift[7:0];
            end
            // R12: no divider writes while reading
            // R17: same for count read
            if (!readA && !readF && lnk_r.bitCount == ssc_pkg::LEN_N) begin
                st_nxt.nReg = lnk_r.shift[15:0];
            end
            if (rWrite) begin
                st_nxt.rReg = lnk_r.shift;
                st_nxt.rReg[ssc_pkg::R_RST_BIT] = 1'b0;
            end
        end
        // R1: done flag on conversion end
        // R2: cleared with sample command
        st_nxt.eoc = (st_r.eoc | adcDone) & ismpl;
        if (adcDone && ismpl) begin
            // R5: result stored as given
            st_nxt.adcResult = adcValue;
        end
        // R8: flag cleared with frequency sample
        st_nxt.cc = st_r.cc & fsmpl;
        unique case (st_r.fcState)
            ssc_pkg::SSC_FC_IDLE: begin
                // R24: counter held at all ones
                st_nxt.fcount = '1;
                if (fsmpl && !stby) begin
                    st_nxt.fcState = ssc_pkg::SSC_FC_COUNT;
                    st_nxt.fcount = '0;
                    st_nxt.winCount = '0;
                end
            end
            ssc_pkg::SSC_FC_COUNT: begin
                if (!fsmpl) begin
                    st_nxt.fcState = ssc_pkg::SSC_FC_IDLE;
                    st_nxt.fcount = '1;
                // R18: divider write during conversion aborts
                end else if ((rWrite && ismpl) || stby) begin
                    st_nxt.fcState = ssc_pkg::SSC_FC_ABORT;
                end else begin
                    if (freqEdge) begin
                        st_nxt.fcount = st_r.fcount + ssc_pkg::FCNT_W'(1);
                    end
                    st_nxt.winCount = st_r.winCount + ssc_pkg::WIN_W'(1);
                    // R7: window over, count valid
                    if (winLast) begin
                        st_nxt.fcState = ssc_pkg::SSC_FC_DONE;
                        st_nxt.cc = 1'b1;
                    end
                end
            end
            ssc_pkg::SSC_FC_DONE, ssc_pkg::SSC_FC_ABORT: begin
                if (!fsmpl) begin
                    st_nxt.fcState = ssc_pkg::SSC_FC_IDLE;
                    st_nxt.fcount = '1;
                end
            end
        endcase
        // R15: open drain drives low on zero
        st_nxt.pinAOe = ~st_nxt.cReg[ssc_pkg::C_OUTA_BIT];
        // R16: push-pull outputs follow bits
        st_nxt.pinB = st_nxt.cReg[ssc_pkg::C_OUTB_BIT];
        st_nxt.pinC = st_nxt.cReg[ssc_pkg::C_OUTC_BIT];
        st_nxt.pinD = st_nxt.rReg[ssc_pkg::R_OUTD_BIT];
        // R11: converter held while command low
        st_nxt.adcHold = ~st_nxt.cReg[ssc_pkg::C_ISMPL_BIT];
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ssc_pkg::ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign sdataOut = sdataOut_r;
    assign outAOut = 1'b0;
    assign outAOe = st_r.pinAOe;
    assign outB = st_r.pinB;
    assign outC = st_r.pinC;
    assign outD = st_r.pinD;
    assign cfg.polarity = st_r.rReg[ssc_pkg::R_POL_BIT];
    assign cfg.bandUpper = st_r.rReg[ssc_pkg::R_BAND_BIT];
    assign cfg.ifFilter = st_r.rReg[ssc_pkg::R_FILT_BIT];
    assign cfg.standby = stby;
    assign cfg.detResp = st_r.rReg[ssc_pkg::R_DET_HI:ssc_pkg::R_DET_LO];
    assign cfg.acqWide = st_r.rReg[ssc_pkg::R_ACQ_BIT];
    assign cfg.refRatio = st_r.rReg[ssc_pkg::R_RATIO_HI:0];
    // R21: zone select from loop bit 15
    assign cfg.upperBandDetectorZone = st_r.nReg[ssc_pkg::N_ZONE_BIT];
    assign cfg.loopRatio = st_r.nReg[ssc_pkg::N_RATIO_HI:0];
    // R14: channel select straight from bit
    assign cfg.adcChan = st_r.cReg[ssc_pkg::C_CHAN_BIT];
    assign cfg.adcHold = st_r.adcHold;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cbMain @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    property p_eocSet;
        adcDone && ismpl |=> st_r.eoc;
    endproperty
    a_eocSet: assert property (p_eocSet) else $error("done flag not set"); // R1

    property p_eocClr;
        !ismpl |=> !st_r.eoc;
    endproperty
    a_eocClr: assert property (p_eocClr) else $error("done flag not cleared"); // R2

    property p_snapA;
        enFall && readA |=> st_r.snapshot[ssc_pkg::SNAP_INC_BIT] == $past(inCs)
            && st_r.snapshot[ssc_pkg::SNAP_EOC_BIT] == $past(st_r.eoc)
            && st_r.snapshot[ssc_pkg::SNAP_AIND_BIT] == $past(inDs);
    endproperty
    a_snapA: assert property (p_snapA) else $error("adc readback wrong"); // R3

    property p_adcVal;
        adcDone && ismpl |=> st_r.adcResult == $past(adcValue);
    endproperty
    a_adcVal: assert property (p_adcVal) else $error("adc result not held"); // R5

    property p_ccSet;
        st_r.fcState == ssc_pkg::SSC_FC_COUNT && winLast && fsmpl && !stby && !rWrite
            |=> st_r.cc && st_r.fcState == ssc_pkg::SSC_FC_DONE;
    endproperty
    a_ccSet: assert property (p_ccSet) else $error("count flag not set"); // R7

    property p_ccClr;
        !fsmpl |=> !st_r.cc;
    endproperty
    a_ccClr: assert property (p_ccClr) else $error("count flag not cleared"); // R8

    property p_snapF;
        enFall && !readA && readF |=> st_r.snapshot[ssc_pkg::SNAP_FIND_BIT] == $past(inDs)
            && st_r.snapshot[ssc_pkg::SNAP_CC_BIT] == $past(st_r.cc);
    endproperty
    a_snapF: assert property (p_snapF) else $error("count readback wrong"); // R9

    property p_abort;
        st_r.fcState == ssc_pkg::SSC_FC_COUNT && fsmpl && rWrite && ismpl
            |=> st_r.fcState == ssc_pkg::SSC_FC_ABORT;
    endproperty
    a_abort: assert property (p_abort) else $error("count not aborted"); // R18

    property p_fcInit;
        !fsmpl ##1 !fsmpl |-> st_r.fcount == '1;
    endproperty
    a_fcInit: assert property (p_fcInit) else $error("counter not all ones"); // R24

    property p_pins;
        outAOe == !st_r.cReg[ssc_pkg::C_OUTA_BIT] && outB == st_r.cReg[ssc_pkg::C_OUTB_BIT]
            && outC == st_r.cReg[ssc_pkg::C_OUTC_BIT] && !outAOut;
    endproperty
    a_pins: assert property (p_pins) else $error("output pins wrong"); // R15

    property p_hold;
        cfg.adcHold == !ismpl;
    endproperty
    a_hold: assert property (p_hold) else $error("converter hold wrong"); // R11

    property p_noWrite;
        capture && (readA || readF) |=> $stable(st_r.nReg) && $stable(st_r.rReg);
    endproperty
    a_noWrite: assert property (p_noWrite) else $error("write during read"); // R12

    property p_cWrite;
        capture && lnk_r.bitCount == ssc_pkg::LEN_C |=> st_r.cReg == $past(lnk_r.shift[7:0]);
    endproperty
    a_cWrite: assert property (p_cWrite) else $error("control byte not loaded"); // R26

    c_eoc: cover property ($rose(st_r.eoc));
    c_cc: cover property ($rose(st_r.cc));
    c_abort: cover property (st_r.fcState == ssc_pkg::SSC_FC_ABORT);
    c_read: cover property (enFall && (readA || readF));

endmodule : ssc_serial_regs

// >>> hw/ssc_pkg.sv
// Purpose: shared constants, types and field layout for the synth serial registers
// Assumes: single reference clock mclk plus host-driven serial clock
// Notes: bit positions are positions inside each shifted word
package ssc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // frame lengths in serial clocks
    localparam logic [4:0] LEN_C = 5'h08;
    localparam logic [4:0] LEN_N = 5'h10;
    localparam logic [4:0] LEN_R = 5'h18;
    localparam logic [4:0] LEN_MAX = 5'h1F;
    localparam logic [4:0] READ_TOP = 5'h17;

    ////////////////////////////////////////////////////////////////////////////
    // control byte fields
    localparam int C_ISMPL_BIT = 7;
    localparam int C_READA_BIT = 6;
    localparam int C_RSVD_BIT = 5;
    localparam int C_CHAN_BIT = 4;
    localparam int C_OUTA_BIT = 3;
    localparam int C_OUTB_BIT = 2;
    localparam int C_OUTC_BIT = 1;
    localparam int C_READF_BIT = 0;
    localparam logic [7:0] C_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // reference divider fields
    localparam int R_POL_BIT = 23;
    localparam int R_RST_BIT = 22;
    localparam int R_BAND_BIT = 21;
    localparam int R_FILT_BIT = 20;
    localparam int R_STBY_BIT = 19;
    localparam int R_DET_HI = 18;
    localparam int R_DET_LO = 17;
    localparam int R_OUTD_BIT = 16;
    localparam int R_ACQ_BIT = 15;
    localparam int R_FSMPL_BIT = 14;
    localparam int R_RATIO_HI = 13;
    localparam logic [23:0] R_RESET = 24'h080000;

    ////////////////////////////////////////////////////////////////////////////
    // loop divider fields
    localparam int N_ZONE_BIT = 15;
    localparam int N_RATIO_HI = 14;
    localparam logic [15:0] N_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // readback word, left aligned in 24 bits
    localparam int SNAP_EOC_BIT = 23;
    localparam int SNAP_INC_BIT = 22;
    localparam int SNAP_ADC_HI = 21;
    localparam int SNAP_ADC_LO = 16;
    localparam int SNAP_AIND_BIT = 15;
    localparam int SNAP_CC_BIT = 23;
    localparam int SNAP_FIND_BIT = 22;
    localparam int FCNT_W = 22;
    localparam int WIN_W = 22;

    ////////////////////////////////////////////////////////////////////////////
    // acquisition windows in reference cycles
    localparam int WIN_NARROW_CYCLES = 524288;
    localparam int WIN_WIDE_CYCLES = 2097152;

    typedef enum logic [1:0] {
        SSC_FC_IDLE = 2'b00,
        SSC_FC_COUNT = 2'b01,
        SSC_FC_DONE = 2'b10,
        SSC_FC_ABORT = 2'b11
    } ssc_fc_e;

    typedef struct packed {
        logic [4:0] bitCount;
        logic [23:0] shift;
    } ssc_link_s;

    typedef struct packed {
        logic polarity;
        logic bandUpper;
        logic ifFilter;
        logic standby;
        logic [1:0] detResp;
        logic acqWide;
        logic [13:0] refRatio;
        logic upperBandDetectorZone;
        logic [14:0] loopRatio;
        logic adcChan;
        logic adcHold;
    } ssc_cfg_s;

    typedef struct packed {
        logic enPrev;
        logic captured;
        logic [7:0] cReg;
        logic [15:0] nReg;
        logic [23:0] rReg;
        logic eoc;
        logic [5:0] adcResult;
        logic cc;
        ssc_fc_e fcState;
        logic [FCNT_W-1:0] fcount;
        logic [WIN_W-1:0] winCount;
        logic freqPrev;
        logic [23:0] snapshot;
        logic pinAOe;
        logic pinB;
        logic pinC;
        logic pinD;
        logic adcHold;
    } ssc_st_s;

    localparam ssc_st_s ST_RESET = '{
        enPrev: 1'b1, captured: 1'b1, cReg: C_RESET, nReg: N_RESET, rReg: R_RESET,
        eoc: 1'b0, adcResult: 6'h00, cc: 1'b0, fcState: SSC_FC_IDLE,
        fcount: {FCNT_W{1'b1}}, winCount: {WIN_W{1'b0}}, freqPrev: 1'b0,
        snapshot: 24'h000000, pinAOe: 1'b1, pinB: 1'b0, pinC: 1'b0, pinD: 1'b0,
        adcHold: 1'b1
    };

endpackage : ssc_pkg

// >>> hw/ssc_sync.sv
// Purpose: two-flop level synchroniser into mclk
// Assumes: inputs are levels from outside the mclk domain
// Notes: only the second stage leaves the module
`timescale 1ns/1ps
module ssc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssc_sync_s;

    ssc_sync_s st_r;
    ssc_sync_s st_nxt;

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= {RESET_VAL, RESET_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

endmodule : ssc_sync

// >>> test/ssc_host_model.sv
// Purpose: host side of the four-wire serial port
// Assumes: sclk idles high and stands still outside frames
// Notes: words are right aligned, n bits sent msb first
`timescale 1ns/1ps
module ssc_host_model (
    output logic sclk,
    output logic serialEnableN,
    output logic sdataIn,
    input wire logic sdataOut
);
    initial begin
        sclk = 1'b1;
        serialEnableN = 1'b1;
        sdataIn = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one frame
    task automatic xfer(input logic [23:0] wd, input int n, output logic [23:0] rd);
        rd = 24'h000000;
        #13;
        serialEnableN = 1'b0;
        #250;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            sdataIn = wd[i];
            #62.5;
            rd = {rd[22:0], sdataOut};
            sclk = 1'b1;
            #62.5;
        end
        #100;
        serialEnableN = 1'b1;
        // released line shows inverse of last bit
        sdataIn = ~sdataIn;
        #437;
    endtask : xfer
endmodule : ssc_host_model

// >>> test/tb_synth_serial_control_readback.sv
// Purpose: self-checking bench of the serial register set
// Assumes: short acquisition windows through parameters
// Notes: control bytes keep the reserved bit at zero
`timescale 1ns/1ps
module tb_synth_serial_control_readback;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic sclk;
    logic serialEnableN;
    logic sdataIn;
    logic sdataOut;
    logic inC = 1'b1;
    logic inD = 1'b1;
    logic freqIn = 1'b0;
    logic adcDone = 1'b0;
    logic [5:0] adcValue = 6'h00;
    logic outAOut;
    logic outAOe;
    logic outB;
    logic outC;
    logic outD;
    ssc_pkg::ssc_cfg_s cfg;
    int errors = 0;
    int samplesChecked = 0;
    int cycles = 0;
    logic [23:0] rd;
    logic [7:0] ctlRow [6] = '{8'h00, 8'h08, 8'h04, 8'h02, 8'h10, 8'h8E};
    logic [4:0] expRow [6] = '{5'h11, 5'h01, 5'h19, 5'h15, 5'h13, 5'h0C};

    ssc_serial_regs #(.NARROW_CYCLES(512), .WIDE_CYCLES(1024)) uut (
        .mclk(mclk), .nrst(nrst), .sclk(sclk), .serialEnableN(serialEnableN),
        .sdataIn(sdataIn), .sdataOut(sdataOut), .inC(inC), .inD(inD),
        .freqIn(freqIn), .adcDone(adcDone), .adcValue(adcValue),
        .outAOut(outAOut), .outAOe(outAOe), .outB(outB), .outC(outC),
        .outD(outD), .cfg(cfg)
    );

    ssc_host_model host (
        .sclk(sclk), .serialEnableN(serialEnableN), .sdataIn(sdataIn), .sdataOut(sdataOut)
    );

    always #25 mclk = ~mclk;

    // steady input: one rising edge every 8 mclk
    always begin
        repeat (4) @(posedge mclk);
        #2;
        freqIn = ~freqIn;
    end

    ////////////////////////////////////////////////////////////////////////////
    // cycle ceiling
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        samplesChecked++;
        if (exp !== got) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [23:0] v, input int n);
        host.xfer(v, n, rd);
    endtask : wr

    task automatic ticks(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : ticks

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        ticks(3);
        check("reset", 24'h23, {sdataOut, outAOe, outB, outC, outD, cfg.standby, cfg.adcHold});
        nrst = 1'b1;
        ticks(3);
        for (int i = 0; i < 6; i++) begin
            wr(ctlRow[i], 8);
            check("ctl", expRow[i], {outAOe, outB, outC, cfg.adcChan, cfg.adcHold});
        end
        wr(24'h83E8, 16);
        check("zoneHi", 24'h83E8, {cfg.upperBandDetectorZone, cfg.loopRatio});
        wr(24'h03E8, 16);
        check("zoneLo", 24'h03E8, {cfg.upperBandDetectorZone, cfg.loopRatio});
        wr(24'hF780CF, 24);
        check("rcfg", 24'hEF, {cfg.polarity, cfg.bandUpper, cfg.ifFilter, cfg.standby,
            cfg.detResp, cfg.acqWide, outD});
        wr(24'h0100CF, 24);
        check("rdiv", 24'h0040CF, {cfg.standby, outD, cfg.refRatio});
        wr(8'h80, 8);
        ticks(1);
        adcValue = 6'h2D;
        adcDone = 1'b1;
        ticks(1);
        adcDone = 1'b0;
        wr(8'hC0, 8);
        host.xfer(24'h000000, 16, rd);
        check("adc16", 24'hED80, rd);
        host.xfer(24'h000000, 9, rd);
        check("adc9", 24'h1DB, rd);
        fork
            host.xfer(24'h0000C0, 8, rd);
            begin
                #600;
                @(posedge mclk);
                #2;
                inC = 1'b0;
            end
        join
        check("adc8", 24'hED, rd);
        host.xfer(24'h000040, 8, rd);
        check("adcPin", 24'hAD, rd);
        host.xfer(24'h000040, 8, rd);
        check("eocClr", 24'h0, {23'h0, rd[7]});
        check("hold", 24'h1, {23'h0, cfg.adcHold});
        wr(8'h01, 8);
        host.xfer(24'h000000, 24, rd);
        check("fIdle", 24'h7FFFFF, rd);
        wr(8'h00, 8);
        wr(24'h0140CF, 24);
        ticks(600);
        wr(8'h01, 8);
        host.xfer(24'h000000, 24, rd);
        check("fDone", 24'hC00040, rd);
        wr(8'h00, 8);
        wr(24'h0100CF, 24);
        wr(8'h01, 8);
        host.xfer(24'h000000, 24, rd);
        check("ccClr", 24'h7FFFFF, rd);
        wr(8'h00, 8);
        wr(24'h0140CF, 24);
        wr(8'h80, 8);
        wr(24'h0140CF, 24);
        ticks(600);
        wr(8'h81, 8);
        host.xfer(24'h000000, 24, rd);
        check("abort", 24'h0, {23'h0, rd[23]});
        report_and_stop();
    end
endmodule : tb_synth_serial_control_readback
